/* File: bench/acc_analog_model.sv */
// Far-side model: analog comparator core and prescaled counter clock
`timescale 1ns/10ps
module acc_analog_model (
  // Clock
  input  wire logic        mclk,
  // Comparator controls from the block
  input  wire logic        comparator_enable,
  input  wire logic        plus_input_select,
  input  wire logic        minus_input_select,
  // Analog levels in millivolts
  input  wire logic [11:0] pin_plus_mv,
  input  wire logic [11:0] ref_mv,
  input  wire logic [11:0] minus0_mv,
  input  wire logic [11:0] minus1_mv,
  // Outputs towards the block
  output logic             compare_raw,
  output logic             counter_clk_fall
);
  // ****************************************************************
  // Comparator and counter clock
  // ****************************************************************
  logic [3:0]  div_q  = 4'h0;
  logic        junk_q = 1'b0;
  logic [11:0] plus_mv;
  logic [11:0] minus_mv;

  // Input routing as chosen by the select bits
  assign plus_mv  = plus_input_select ? ref_mv : pin_plus_mv;
  assign minus_mv = minus_input_select ? minus1_mv : minus0_mv;
  // Unpowered core chatters, so a stale level cannot pass for a result
  assign compare_raw = comparator_enable ? (plus_mv > minus_mv) : junk_q;
  // Falling edge of the prescaled counter clock, one pulse per 16 cycles
  assign counter_clk_fall = (div_q == 4'h7);

  // Free-running divider and chatter source
  always @(posedge mclk)
  begin
    div_q  <= div_q + 4'h1;
    junk_q <= ~junk_q;
  end
endmodule

/* File: bench/acc_ctrl_bench.sv */
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
module acc_ctrl_bench;
  // ****************************************************************
  // Signals, design and far side
  // ****************************************************************
  logic        mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0]  reg_addr = 2'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic        pin_direction = 1'b1, sleep_active = 1'b0, instr_done = 1'b0;
  logic        counter_on = 1'b0, gate_enable = 1'b0, gate_pin = 1'b0;
  logic        compare_raw, counter_clk_fall, comparator_enable, hysteresis_enable;
  logic        plus_input_select, minus_input_select, result_pin_out, result_pin_oe;
  logic        wake_req, irq_req, counter_alt_clock, count_gate;
  logic [11:0] pin_mv = 12'h12c;
  int          fails = 0, checks_done = 0;

  acc_ctrl dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_raw(compare_raw),
    .comparator_enable(comparator_enable), .hysteresis_enable(hysteresis_enable),
    .plus_input_select(plus_input_select), .minus_input_select(minus_input_select),
    .pin_direction(pin_direction), .result_pin_out(result_pin_out), .result_pin_oe(result_pin_oe),
    .sleep_active(sleep_active), .instr_done(instr_done), .wake_req(wake_req), .irq_req(irq_req),
    .counter_on(counter_on), .gate_enable(gate_enable), .counter_clk_fall(counter_clk_fall),
    .gate_pin(gate_pin), .counter_alt_clock(counter_alt_clock), .count_gate(count_gate));

  acc_analog_model u_far (.mclk(mclk), .comparator_enable(comparator_enable),
    .plus_input_select(plus_input_select), .minus_input_select(minus_input_select),
    .pin_plus_mv(pin_mv), .ref_mv(12'h320), .minus0_mv(12'h1f4), .minus1_mv(12'h1f4),
    .compare_raw(compare_raw), .counter_clk_fall(counter_clk_fall));

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // Comparison, bus and wait helpers
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    chk("read data", reg_rdata, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic setv(input logic [11:0] v);
    @(posedge mclk);
    pin_mv <= v;
  endtask
  task automatic wait_fall();
    repeat (20)
    begin
      @(posedge mclk);
      #1;
      if (counter_clk_fall === 1'b1)
        return;
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h02);
    rd(2'h2, 8'h00);
    wr(2'h1, 8'hff);
    rd(2'h1, 8'h1b);
    chk("hysteresis", hysteresis_enable, 8'h01);
    wr(2'h1, 8'h02);
    wr(2'h3, 8'hff);
    rd(2'h3, 8'h00);
    wr(2'h0, 8'hff);
    wt(8);
    rd(2'h0, 8'hb5);
    chk("enable", comparator_enable, 8'h01);
    chk("plus select", plus_input_select, 8'h01);
    wr(2'h0, 8'hfb);
    wt(8);
    rd(2'h0, 8'hf1);
    wr(2'h0, 8'h7f);
    wt(8);
    rd(2'h0, 8'h35);
    chk("enable off", comparator_enable, 8'h00);
  endtask

  task automatic t_pin();
    @(posedge mclk);
    pin_direction <= 1'b0;
    wr(2'h0, 8'ha0);
    wt(8);
    chk("pin oe", result_pin_oe, 8'h01);
    chk("pin low", result_pin_out, 8'h00);
    setv(12'h2bc);
    wt(10);
    chk("pin high", result_pin_out, 8'h01);
    @(posedge mclk);
    pin_direction <= 1'b1;
    wt(3);
    chk("pin input", result_pin_oe, 8'h00);
    @(posedge mclk);
    pin_direction <= 1'b0;
    wr(2'h0, 8'h80);
    wt(3);
    chk("pin internal", result_pin_oe, 8'h00);
    wr(2'h0, 8'h20);
    wt(3);
    chk("pin off", result_pin_oe, 8'h00);
  endtask

  task automatic t_flag();
    setv(12'h12c);
    wr(2'h0, 8'h80);
    wt(120);
    rd(2'h0, 8'h80);
    wr(2'h2, 8'h00);
    rd(2'h2, 8'h10);
    setv(12'h2bc);
    wt(10);
    rd(2'h2, 8'h11);
    wr(2'h2, 8'h00);
    wt(10);
    rd(2'h2, 8'h10);
    setv(12'h12c);
    wt(10);
    rd(2'h2, 8'h10);
    setv(12'h2bc);
    wt(10);
    wr(2'h0, 8'h80);
    wr(2'h2, 8'h00);
    setv(12'h12c);
    wt(10);
    rd(2'h2, 8'h11);
  endtask

  task automatic t_sleep();
    wr(2'h2, 8'h02);
    sleep_active <= 1'b1;
    rd(2'h0, 8'h80);
    setv(12'h2bc);
    wt(10);
    chk("wake one enable", wake_req, 8'h00);
    rd(2'h0, 8'hc0);
    wr(2'h2, 8'h0e);
    setv(12'h12c);
    wt(10);
    chk("wake", wake_req, 8'h01);
    chk("irq asleep", irq_req, 8'h00);
    @(posedge mclk);
    sleep_active <= 1'b0;
    wt(2);
    chk("irq held", irq_req, 8'h00);
    @(posedge mclk);
    instr_done <= 1'b1;
    @(posedge mclk);
    instr_done <= 1'b0;
    wt(2);
    chk("irq taken", irq_req, 8'h01);
    wr(2'h2, 8'h00);
  endtask

  task automatic t_gate();
    counter_on  <= 1'b1;
    gate_enable <= 1'b1;
    wt(4);
    chk("gate pin low", count_gate, 8'h00);
    @(posedge mclk);
    gate_pin <= 1'b1;
    wt(4);
    chk("gate pin high", count_gate, 8'h01);
    wr(2'h1, 8'h00);
    wt(3);
    chk("gate result low", count_gate, 8'h00);
    setv(12'h2bc);
    wt(10);
    chk("gate result high", count_gate, 8'h01);
    wr(2'h1, 8'h01);
    wait_fall();
    setv(12'h12c);
    wt(10);
    chk("gate held", count_gate, 8'h01);
    wait_fall();
    wt(1);
    chk("gate latched", count_gate, 8'h00);
    @(posedge mclk);
    counter_on <= 1'b0;
    wt(2);
    chk("gate idle", count_gate, 8'h01);
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_pin();
    t_flag();
    t_sleep();
    t_gate();
    tally_and_finish();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (5000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end
endmodule

/* File: bench/acc_ctrl_properties.sv */
// Port checker for the comparator control block
`timescale 1ns/10ps
module acc_ctrl_properties (
  // Clock, reset and register port
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Controls, pin, core and gate
  input wire logic       comparator_enable,
  input wire logic       hysteresis_enable,
  input wire logic       plus_input_select,
  input wire logic       pin_direction,
  input wire logic       result_pin_oe,
  input wire logic       sleep_active,
  input wire logic       wake_req,
  input wire logic       irq_req,
  input wire logic       counter_on,
  input wire logic       gate_enable,
  input wire logic       count_gate
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  a_reset_state: assert property ($rose(reset_n) |->
    !comparator_enable && !hysteresis_enable && !result_pin_oe)
    else $error("outputs not at reset state");
  a_on_follows_write: assert property (reg_wr && reg_addr == acc_pkg::OFF_CTRL0 |=>
    comparator_enable == $past(reg_wdata[acc_pkg::C0_ON]))
    else $error("comparator enable not from write");
  a_plus_follows_write: assert property (reg_wr && reg_addr == acc_pkg::OFF_CTRL0 |=>
    plus_input_select == $past(reg_wdata[acc_pkg::C0_PLUS]))
    else $error("plus select not from write");
  a_pin_needs_on: assert property (result_pin_oe |->
    (comparator_enable || $past(comparator_enable)) && !$past(pin_direction))
    else $error("pin driven without its conditions");
  a_ctrl0_gaps_zero: assert property (reg_rd && reg_addr == acc_pkg::OFF_CTRL0 |=>
    reg_rdata[3] == 1'b0 && reg_rdata[1] == 1'b0)
    else $error("unimplemented bits read nonzero");
  a_off_result_zero: assert property (reg_rd && reg_addr == acc_pkg::OFF_CTRL0 &&
    !comparator_enable && !$past(comparator_enable, 8) |=> !reg_rdata[acc_pkg::C0_RESULT])
    else $error("result bit set while comparator off");
  a_wake_in_sleep: assert property (wake_req |-> sleep_active)
    else $error("wake request outside sleep");
  a_irq_not_sleep: assert property (irq_req |-> !sleep_active)
    else $error("interrupt taken while asleep");
  a_irq_after_wake: assert property ($fell(sleep_active) && $past(wake_req) |-> !irq_req)
    else $error("interrupt before next instruction");
  a_gate_idle_open: assert property (!(counter_on && gate_enable) |-> count_gate)
    else $error("gate closed while gating off");

  c_wake: cover property (wake_req);
  c_irq: cover property (irq_req);
  c_pin_drive: cover property (result_pin_oe);
  c_gate_closed: cover property (counter_on && gate_enable && !count_gate);
endmodule

bind acc_ctrl acc_ctrl_properties u_props (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .comparator_enable(comparator_enable), .hysteresis_enable(hysteresis_enable),
  .plus_input_select(plus_input_select), .pin_direction(pin_direction), .result_pin_oe(result_pin_oe),
  .sleep_active(sleep_active), .wake_req(wake_req), .irq_req(irq_req), .counter_on(counter_on),
  .gate_enable(gate_enable), .count_gate(count_gate));

/* File: rtl/acc_ctrl.sv */
// Top of the analog comparator control block
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module acc_ctrl (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Analog front end
  input  wire logic       compare_raw,
  output logic            comparator_enable,
  output logic            hysteresis_enable,
  output logic            plus_input_select,
  output logic            minus_input_select,
  // Result pin
  input  wire logic       pin_direction,
  output logic            result_pin_out,
  output logic            result_pin_oe,
  // Core sleep and interrupt
  input  wire logic       sleep_active,
  input  wire logic       instr_done,
  output logic            wake_req,
  output logic            irq_req,
  // Counter gate
  input  wire logic       counter_on,
  input  wire logic       gate_enable,
  input  wire logic       counter_clk_fall,
  input  wire logic       gate_pin,
  output logic            counter_alt_clock,
  output logic            count_gate
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl0_d;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl1_d;
  logic [7:0] irq_q;
  logic [7:0] irq_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic [6:0] settle_q;
  logic [6:0] settle_d;
  logic       hold_q;
  logic       hold_d;
  logic       gsync_q;
  logic       gsync_d;
  logic       pin_q;
  logic       pin_d;
  logic       oe_q;
  logic       oe_d;
  logic       cmp_s;
  logic       gate_pin_s;
  logic       phase1_en;
  logic       read_load;
  logic       cmp_result;
  logic       result_q;
  logic       mismatch;
  logic       change_pulse;
  logic       ctrl0_wr;
  logic       ctrl1_wr;
  logic       irq_wr;
  logic       enables_ok;
  logic       cmp_gate_src;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************

  // Comparator output and gate pin come from outside the clock domain
  acc_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in ({compare_raw, gate_pin}),
    .sync_out ({cmp_s, gate_pin_s})
  );

  // ****************************************************************
  // Instruction clock phases
  // ****************************************************************

  // Four-phase divider, first phase gives the latch enable
  always_comb
  begin
    phase_d = phase_q + 2'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      phase_q <= acc_pkg::PHASE_FIRST;
    else
      phase_q <= phase_d;
  end

  assign phase1_en = (phase_q == acc_pkg::PHASE_FIRST);

  // ****************************************************************
  // Register decode
  // ****************************************************************

  // Write strobes per register
  assign ctrl0_wr = reg_wr && (reg_addr == acc_pkg::OFF_CTRL0);
  assign ctrl1_wr = reg_wr && (reg_addr == acc_pkg::OFF_CTRL1);
  assign irq_wr   = reg_wr && (reg_addr == acc_pkg::OFF_IRQ);

  // A read or a write of control register 0 reloads the read latch
  assign read_load = (reg_rd || reg_wr) && (reg_addr == acc_pkg::OFF_CTRL0);

  // ****************************************************************
  // Comparator result and mismatch
  // ****************************************************************

  // Result with polarity, forced low while the comparator is off
  assign cmp_result = ctrl0_q[acc_pkg::C0_ON] & (cmp_s ^ ctrl0_q[acc_pkg::C0_INV]);

  acc_mismatch u_mismatch (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .phase1_en    (phase1_en),
    .read_load    (read_load),
    .result_in    (cmp_result),
    .result_q     (result_q),
    .mismatch     (mismatch),
    .change_pulse (change_pulse)
  );

  // ****************************************************************
  // Control and flag registers
  // ****************************************************************

  // Next register values; the hardware set wins over a software clear
  always_comb
  begin
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    irq_d   = irq_q;
    if (ctrl0_wr)
      ctrl0_d = reg_wdata & acc_pkg::C0_WMASK;
    if (ctrl1_wr)
      ctrl1_d = reg_wdata & acc_pkg::C1_WMASK;
    if (irq_wr)
      irq_d = reg_wdata & acc_pkg::IR_WMASK;
    if (change_pulse)
      irq_d[acc_pkg::IR_FLAG] = 1'b1;
  end

  // Reset returns both control registers with the comparator off
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ctrl0_q <= acc_pkg::C0_RESET;
      ctrl1_q <= acc_pkg::C1_RESET;
      irq_q   <= acc_pkg::IR_RESET;
    end
    else
    begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      irq_q   <= irq_d;
    end
  end

  // ****************************************************************
  // Bias settling status
  // ****************************************************************

  // Counts down after enable; held reloaded while the comparator is off
  always_comb
  begin
    settle_d = settle_q;
    if (!ctrl0_q[acc_pkg::C0_ON])
      settle_d = acc_pkg::BIAS_CNT;
    else if (settle_q != 7'h00)
      settle_d = settle_q - 7'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      settle_q <= acc_pkg::BIAS_CNT;
    else
      settle_q <= settle_d;
  end

  // ****************************************************************
  // Read data
  // ****************************************************************

  // Read mux, registered so data stands in the following cycle
  always_comb
  begin
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      unique case (reg_addr)
        acc_pkg::OFF_CTRL0:
        begin
          rdata_d = ctrl0_q;
          rdata_d[acc_pkg::C0_RESULT] = result_q;
        end
        acc_pkg::OFF_CTRL1:
          rdata_d = ctrl1_q;
        acc_pkg::OFF_IRQ:
        begin
          rdata_d = irq_q;
          rdata_d[acc_pkg::IR_SETTLED] = ctrl0_q[acc_pkg::C0_ON] && (settle_q == 7'h00);
        end
        default:
          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;

  // ****************************************************************
  // Analog controls
  // ****************************************************************

  // Enable runs independent of sleep
  assign comparator_enable  = ctrl0_q[acc_pkg::C0_ON];
  assign plus_input_select  = ctrl0_q[acc_pkg::C0_PLUS];
  assign minus_input_select = ctrl0_q[acc_pkg::C0_MINUS];
  assign hysteresis_enable  = ctrl1_q[acc_pkg::C1_HYST];
  assign counter_alt_clock  = ctrl1_q[acc_pkg::C1_ALT_CLK];

  // ****************************************************************
  // Result pin
  // ****************************************************************

  // Pin drive needs drive bit, comparator on and pin set as output
  always_comb
  begin
    pin_d = result_q;
    oe_d  = ctrl0_q[acc_pkg::C0_DRIVE]
            & ctrl0_q[acc_pkg::C0_ON]
            & ~pin_direction;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      pin_q <= 1'b0;
      oe_q  <= 1'b0;
    end
    else
    begin
      pin_q <= pin_d;
      oe_q  <= oe_d;
    end
  end

  assign result_pin_out = pin_q;
  assign result_pin_oe  = oe_q;

  // ****************************************************************
  // Wake and interrupt
  // ****************************************************************

  // Both the change enable and peripheral enable are needed to wake
  assign enables_ok = irq_q[acc_pkg::IR_FLAG]
                      & irq_q[acc_pkg::IR_CIE]
                      & irq_q[acc_pkg::IR_PERIPHERAL_IRQ_EN];
  assign wake_req   = sleep_active & enables_ok;

  // Vector held off until the instruction after sleep has retired
  always_comb
  begin
    hold_d = hold_q;
    if (wake_req)
      hold_d = 1'b1;
    else if (instr_done)
      hold_d = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      hold_q <= 1'b0;
    else
      hold_q <= hold_d;
  end

  assign irq_req = enables_ok
                   & irq_q[acc_pkg::IR_GIE]
                   & ~sleep_active
                   & ~hold_q;

  // ****************************************************************
  // Counter gate
  // ****************************************************************

  // Result captured on counter clock falling edge after prescale
  always_comb
  begin
    gsync_d = counter_clk_fall ? result_q : gsync_q;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      gsync_q <= 1'b0;
    else
      gsync_q <= gsync_d;
  end

  // Synchronised or direct comparator result as gate source
  assign cmp_gate_src = ctrl1_q[acc_pkg::C1_SYNC] ? gsync_q : result_q;

  // Gate applies only while the counter runs with gating on
  assign count_gate = (counter_on & gate_enable)
                      ? (ctrl1_q[acc_pkg::C1_GSS] ? gate_pin_s : cmp_gate_src)
                      : 1'b1;

endmodule

/* File: rtl/acc_mismatch.sv */
// Mismatch detector with read latch and first-phase latch
`timescale 1ns/10ps
module acc_mismatch (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // Controls
  input  wire logic phase1_en,
  input  wire logic read_load,
  input  wire logic result_in,
  // Status
  output logic      result_q,
  output logic      mismatch,
  output logic      change_pulse
);

  logic phase_q;
  logic phase_d;
  logic read_q;
  logic read_d;
  logic prev_q;

  // Next latch values
  always_comb
  begin
    phase_d = phase1_en ? result_in : phase_q;
    read_d  = read_load ? phase_q : read_q;
  end

  // Latch registers
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      phase_q <= 1'b0;
      read_q  <= 1'b0;
      prev_q  <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      read_q  <= read_d;
      prev_q  <= mismatch;
    end
  end

  // Compare and edge detect
  assign mismatch     = phase_q ^ read_q;
  assign change_pulse = mismatch & ~prev_q;
  assign result_q     = phase_q;

endmodule

/* File: rtl/acc_pkg.sv */
// Constants for the analog comparator control block
package acc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W    = 2;
  localparam int          DATA_W    = 8;
  localparam logic [1:0]  OFF_CTRL0 = 2'h0;
  localparam logic [1:0]  OFF_CTRL1 = 2'h1;
  localparam logic [1:0]  OFF_IRQ   = 2'h2;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int C0_ON      = 7;
  localparam int C0_RESULT  = 6;
  localparam int C0_DRIVE   = 5;
  localparam int C0_INV     = 4;
  localparam int C0_PLUS    = 2;
  localparam int C0_MINUS   = 0;
  localparam int C1_ALT_CLK = 4;
  localparam int C1_HYST    = 3;
  localparam int C1_GSS     = 1;
  localparam int C1_SYNC    = 0;
  localparam int IR_FLAG    = 0;
  localparam int IR_CIE     = 1;
  localparam int IR_PERIPHERAL_IRQ_EN    = 2;
  localparam int IR_GIE     = 3;
  localparam int IR_SETTLED = 4;

  // ****************************************************************
  // Reset values and writable masks
  // ****************************************************************
  localparam logic [7:0] C0_RESET = 8'h00;
  localparam logic [7:0] C0_WMASK = 8'hb5;
  localparam logic [7:0] C1_RESET = 8'h02;
  localparam logic [7:0] C1_WMASK = 8'h1b;
  localparam logic [7:0] IR_RESET = 8'h00;
  localparam logic [7:0] IR_WMASK = 8'h0f;

  // ****************************************************************
  // Clock phases and timing
  // ****************************************************************
  localparam int         PHASE_W        = 2;
  localparam logic [1:0] PHASE_FIRST    = 2'h0;
  localparam logic [1:0] PHASE_SECOND   = 2'h1;
  localparam int         CLK_PERIOD_PS  = 10000;
  localparam int         BIAS_SETTLE_US = 1;
  localparam int         BIAS_CYCLES    = (BIAS_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int         SETTLE_W       = 7;
  localparam logic [6:0] BIAS_CNT       = 7'(BIAS_CYCLES);

endpackage

/* File: rtl/acc_sync2.sv */
// Two flip-flop synchroniser for pin-side levels
`timescale 1ns/10ps
module acc_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Two stages, first read only by the second
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule
